// ### hdl/rbow_timer.sv
// heartbeat activity timer
`timescale 1ns/1ps
`include "rbow_defines.svh"
module rbow_timer #(
  parameter int unsigned TIMEOUT_CYCLES = `RBOW_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic heartbeat,
  output logic expired
);
  localparam int W = $clog2(TIMEOUT_CYCLES + 1);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic last_hb;
  logic next_last_hb;
  logic next_expired;

  always_comb begin
    next_last_hb = heartbeat;
    next_count = count;
    next_expired = 1'b0;
    if (heartbeat != last_hb) begin
      next_count = '0;
    end else if (count != W'(TIMEOUT_CYCLES)) begin
      next_count = count + W'(1);
    end
    if (next_count == W'(TIMEOUT_CYCLES)) begin
      next_expired = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      last_hb <= 1'b0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      last_hb <= next_last_hb;
      expired <= next_expired;
    end
  end
endmodule : rbow_timer

// ### hdl/rbow_top.sv
// relay board output stage with heartbeat watchdog
`timescale 1ns/1ps
`include "rbow_defines.svh"
module rbow_top #(
  parameter int unsigned TIMEOUT_CYCLES = `RBOW_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input rbow_pkg::rbow_cmd_type cmd,
  input wire logic cmd_valid,
  input wire logic trip_clear,
  output logic [7:0] valve_out,
  output logic photometer_pump,
  output logic photometer_heater,
  output logic ozone_gen_heater,
  output logic heartbeat_indicator,
  output logic titration_valve_indicator,
  output logic meas_ref_valve_indicator,
  output logic ozone_gen_valve_indicator,
  output logic photometer_pump_indicator,
  output logic cal_gas_valve_indicator,
  output logic diluent_valve_indicator,
  output logic photometer_heater_indicator,
  output logic ozone_gen_heater_indicator,
  output logic tripped
);
  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command latch
  rbow_pkg::rbow_cmd_type held;
  rbow_pkg::rbow_cmd_type next_held;
  always_comb begin
    next_held = held;
    if (cmd_valid) begin
      next_held = cmd;
    end
  end
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      held <= rbow_pkg::rbow_cmd_type'(`RBOW_CMD_RESET);
    end else begin
      held <= next_held;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog: host must keep toggling the heartbeat
  logic expired;
  rbow_timer #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_sync),
    .heartbeat(held.heartbeat),
    .expired(expired)
  );

  rbow_pkg::rbow_state_type state;
  rbow_pkg::rbow_state_type next_state;
  always_comb begin
    case (state)
      rbow_pkg::RBOW_RUN: begin
        next_state = expired ? rbow_pkg::RBOW_TRIPPED : rbow_pkg::RBOW_RUN;
      end
      rbow_pkg::RBOW_TRIPPED: begin
        // stays shut until the heartbeat moves again and software clears
        if (trip_clear && !expired) begin
          next_state = rbow_pkg::RBOW_RUN;
        end else begin
          next_state = rbow_pkg::RBOW_TRIPPED;
        end
      end
      default: next_state = rbow_pkg::RBOW_TRIPPED;
    endcase
  end
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= rbow_pkg::RBOW_RUN;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, forced off while tripped
  logic shut;
  logic [7:0] next_valve;
  logic next_pump;
  logic next_ph_heat;
  logic next_oz_heat;
  // shut follows the next state, so the forced outputs and the tripped flag
  // change on the same edge when a trip starts and when it is cleared
  assign shut = (next_state == rbow_pkg::RBOW_TRIPPED);
  function automatic logic rbow_gate(input logic on, input logic off);
    return on && !off;
  endfunction : rbow_gate
  genvar g;
  generate
    for (g = 0; g < `RBOW_VALVE_GROUPS; g++) begin : gen_grp
      localparam int LO = g * `RBOW_VALVES_PER_GROUP;
      always_comb begin
        next_valve[LO +: `RBOW_VALVES_PER_GROUP] = shut ? '0 :
          held.valve[LO +: `RBOW_VALVES_PER_GROUP];
      end
    end
  endgenerate
  always_comb begin
    next_pump = rbow_gate(held.photometer_pump, shut);
    next_ph_heat = rbow_gate(held.photometer_heater, shut);
    next_oz_heat = rbow_gate(held.ozone_gen_heater, shut);
  end
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      valve_out <= 8'h00;
    end else begin
      valve_out <= next_valve;
    end
  end

  // pump and lamp heaters
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      photometer_pump <= 1'b0;
      photometer_heater <= 1'b0;
      ozone_gen_heater <= 1'b0;
    end else begin
      photometer_pump <= next_pump;
      photometer_heater <= next_ph_heat;
      ozone_gen_heater <= next_oz_heat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status: heartbeat lamp and trip flag
  logic next_hb_ind;
  logic next_tripped;
  always_comb begin
    next_hb_ind = held.heartbeat;
    next_tripped = shut;
  end
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      heartbeat_indicator <= 1'b0;
      tripped <= 1'b0;
    end else begin
      heartbeat_indicator <= next_hb_ind;
      tripped <= next_tripped;
    end
  end

  // indicators mirror the driven outputs, so they also show the trip
  assign titration_valve_indicator = valve_out[`RBOW_VALVE_TITRATION];
  assign meas_ref_valve_indicator = valve_out[`RBOW_VALVE_MEAS_REF];
  assign photometer_pump_indicator = photometer_pump;
  assign photometer_heater_indicator = photometer_heater;
  assign ozone_gen_heater_indicator = ozone_gen_heater;
  assign diluent_valve_indicator = valve_out[`RBOW_VALVE_DILUENT];
  assign cal_gas_valve_indicator = valve_out[`RBOW_VALVE_CAL_GAS];
  assign ozone_gen_valve_indicator = valve_out[`RBOW_VALVE_OZONE_GEN];
endmodule : rbow_top

// ### include/rbow_defines.svh
// constants for the relay board output watchdog
// Summary of operation
// - apply commands received from motherboard to outputs
// - two driver groups, four valves each
// - control source, diluent, ozone and photometer valves
// - switch ozone and photometer lamp heaters
// - steady heartbeat thirty seconds forces all valves, pump and heaters off
// - titration and meas/ref indicators follow valves
// - pump indicator follows pump output
// - heater indicators follow heater outputs
// - diluent, cal gas, ozone indicators follow valves
`ifndef RBOW_DEFINES_SVH
`define RBOW_DEFINES_SVH
`define RBOW_CLK_HZ 32'h05f5e100
`define RBOW_TIMEOUT_S 32'h0000001e
`define RBOW_TIMEOUT_CYCLES (`RBOW_CLK_HZ * `RBOW_TIMEOUT_S)
`define RBOW_VALVE_DILUENT 0
`define RBOW_VALVE_CAL_GAS 1
`define RBOW_VALVE_OZONE_GEN 2
`define RBOW_VALVE_TITRATION 3
`define RBOW_VALVE_MEAS_REF 4
`define RBOW_VALVES_PER_GROUP 4
`define RBOW_VALVE_GROUPS 2
`define RBOW_CMD_RESET 12'h000
`endif

// ### include/rbow_pkg.sv
// types for the relay board output watchdog
package rbow_pkg;
  typedef struct packed {
    logic [7:0] valve;
    logic photometer_pump;
    logic photometer_heater;
    logic ozone_gen_heater;
    logic heartbeat;
  } rbow_cmd_type;
  typedef enum logic [1:0] {
    RBOW_RUN = 2'b01,
    RBOW_TRIPPED = 2'b10
  } rbow_state_type;
endpackage : rbow_pkg

// ### tb/rbow_host_model.sv
// motherboard model relaying host commands
`timescale 1ns/1ps
module rbow_host_model (
  input wire logic clk,
  output rbow_pkg::rbow_cmd_type cmd,
  output logic cmd_valid
);
  logic beat = 1'h0;
  initial begin
    cmd = '0;
    cmd_valid = 1'h0;
  end
  task automatic send(input logic [10:0] v, input logic move);
    @(negedge clk);
    if (move) beat = ~beat;
    cmd = {v, beat};
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd_valid = 1'h0;
    // no longer qualified, so do not leave the last word on the lines
    cmd = ~cmd;
  endtask : send
endmodule : rbow_host_model

// ### tb/rbow_top_properties.sv
// port checker for the relay board output watchdog
`timescale 1ns/1ps
module rbow_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input rbow_pkg::rbow_cmd_type cmd,
  input wire logic cmd_valid,
  input wire logic trip_clear,
  input wire logic tripped,
  input wire logic [7:0] valve_out,
  input wire logic photometer_pump,
  input wire logic photometer_heater,
  input wire logic ozone_gen_heater,
  input wire logic heartbeat_indicator,
  input wire logic titration_valve_indicator,
  input wire logic meas_ref_valve_indicator,
  input wire logic ozone_gen_valve_indicator,
  input wire logic cal_gas_valve_indicator,
  input wire logic diluent_valve_indicator,
  input wire logic photometer_pump_indicator,
  input wire logic photometer_heater_indicator,
  input wire logic ozone_gen_heater_indicator
);
  // cycles the heartbeat has held still; margins cover the reset sync
  int unsigned still;
  logic last_ind;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      still <= 0;
      last_ind <= 1'b0;
    end else begin
      last_ind <= heartbeat_indicator;
      if (heartbeat_indicator != last_ind) begin
        still <= 0;
      end else if (still < TIMEOUT_CYCLES + 9) begin
        still <= still + 1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cmd; cmd_valid ##2 !tripped |-> {valve_out, photometer_pump,
    photometer_heater, ozone_gen_heater} == $past(cmd[11:1], 2); endproperty
  a_cmd: assert property (p_cmd) else $error("outputs off cmd");
  property p_off; tripped |-> !(|{valve_out, photometer_pump,
    photometer_heater, ozone_gen_heater}); endproperty
  a_off: assert property (p_off) else $error("output on in trip");
  property p_ind; {meas_ref_valve_indicator, titration_valve_indicator,
    ozone_gen_valve_indicator, cal_gas_valve_indicator,
    diluent_valve_indicator} == valve_out[4:0]; endproperty
  a_ind: assert property (p_ind) else $error("valve lamp wrong");
  property p_indp; photometer_pump_indicator == photometer_pump; endproperty
  a_indp: assert property (p_indp) else $error("pump lamp wrong");
  property p_indh; {photometer_heater_indicator, ozone_gen_heater_indicator}
    == {photometer_heater, ozone_gen_heater}; endproperty
  a_indh: assert property (p_indh) else $error("heater lamp wrong");
  property p_early; $rose(tripped) |-> still >= TIMEOUT_CYCLES - 4;
  endproperty
  a_early: assert property (p_early) else $error("early trip");
  property p_late; still == TIMEOUT_CYCLES + 6 |-> tripped; endproperty
  a_late: assert property (p_late) else $error("no trip");
  property p_stick; tripped && !trip_clear |=> tripped; endproperty
  a_stick: assert property (p_stick) else $error("trip dropped");
endmodule : rbow_checker
bind rbow_top rbow_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.*);

// ### tb/test_rbow_top.sv
// self-checking bench for the relay board output watchdog
`timescale 1ns/1ps
module test_rbow_top;
  localparam int T = 20;
  logic clk = 1'h0, rst_n = 1'h0, trip_clear = 1'h0, trip_m = 1'h0;
  rbow_pkg::rbow_cmd_type cmd;
  logic cmd_valid, photometer_pump, photometer_heater, ozone_gen_heater;
  logic [7:0] valve_out;
  logic tripped, heartbeat_indicator, titration_valve_indicator;
  logic meas_ref_valve_indicator, ozone_gen_valve_indicator;
  logic cal_gas_valve_indicator, diluent_valve_indicator;
  logic photometer_pump_indicator, photometer_heater_indicator;
  logic ozone_gen_heater_indicator;
  logic [10:0] last = 11'h0;
  logic hb = 1'h0;
  logic [31:0] seed = 32'hd7d665e0;
  int failures = 0, num_checks = 0, cycles = 0;
  always #5 clk = ~clk;
  rbow_host_model HOST (.*);
  rbow_top #(.TIMEOUT_CYCLES(T)) DUT (.*);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic compare(input string what);
    logic [10:0] e;
    logic [20:0] g;
    logic [20:0] x;
    e = trip_m ? 11'h0 : last;
    x = {trip_m, e, e[7:0], hb};
    g = {tripped, valve_out, photometer_pump, photometer_heater,
      ozone_gen_heater, meas_ref_valve_indicator, titration_valve_indicator,
      ozone_gen_valve_indicator, cal_gas_valve_indicator,
      diluent_valve_indicator, photometer_pump_indicator,
      photometer_heater_indicator, ozone_gen_heater_indicator,
      heartbeat_indicator};
    num_checks++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, x, g);
    end
  endtask : compare
  task automatic apply(input logic [10:0] v, input logic move);
    HOST.send(v, move);
    if (move) hb = ~hb;
    last = v;
    @(negedge clk);
    compare("outputs");
  endtask : apply
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    repeat (3) @(negedge clk);
    compare("reset");
    for (int i = 0; i < 11; i++) apply(11'h1 << i, 1'h1);
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      apply(seed[10:0], 1'h1);
    end
    // gaps just short of the interval must never trip
    for (int i = 0; i < 4; i++) begin
      apply(last, 1'h1);
      repeat (T - 6) @(negedge clk);
    end
    apply(11'h7ff, 1'h0);
    repeat (T + 8) @(negedge clk);
    trip_m = 1'h1;
    compare("trip");
    apply(11'h5a5, 1'h1);
    trip_clear = 1'h1;
    repeat (4) @(negedge clk);
    trip_clear = 1'h0;
    trip_m = 1'h0;
    compare("cleared");
    apply(11'h3c3, 1'h1);
    tally_and_finish();
  end
endmodule : test_rbow_top
